// *** rtl/ear_pkg.sv ***
// Constants and types shared by the egress action resolver
package ear_pkg;

  // ==========================================================
  // Field widths
  localparam int ENCAP_W = 7;
  localparam int POP_W = 5;
  localparam int BASE_W = 10;
  localparam int OFFS_W = 24;
  localparam int MIDX_W = 8;
  localparam int KEY_W = 4;
  localparam int MAP_W = 11;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_FRAMES_LSB = 0;
  localparam int STAT_RSVD_LSB = 16;

  // ==========================================================
  // Pop word override encoding
  localparam logic [POP_W-1:0] POP_USE_HEADER = 5'h00;
  localparam logic [POP_W-1:0] POP_NONE = 5'h01;
  localparam logic [POP_W-1:0] POP_MAX = 5'h15;

  // Protection choice
  typedef enum logic [1:0] {
    EAR_PROT_NONE = 2'b00,
    EAR_PROT_ACTIVE = 2'b01,
    EAR_PROT_INACTIVE = 2'b10,
    EAR_PROT_RSVD = 2'b11
  } ear_prot_e;

  // Mapping key encoding
  typedef enum logic [KEY_W-1:0] {
    EAR_KEY_QOS = 4'b0000,
    EAR_KEY_DP_QOS = 4'b0001,
    EAR_KEY_DSCP = 4'b0010,
    EAR_KEY_DP_DSCP = 4'b0011,
    EAR_KEY_DP_TOS = 4'b0100,
    EAR_KEY_PCP = 4'b0101,
    EAR_KEY_DP_PCP = 4'b0110,
    EAR_KEY_DEI_PCP = 4'b0111,
    EAR_KEY_TC = 4'b1000,
    EAR_KEY_DP_TC = 4'b1001,
    EAR_KEY_POP_PCP = 4'b1010,
    EAR_KEY_DP_POP_PCP = 4'b1011,
    EAR_KEY_POP_DEI_PCP = 4'b1100,
    EAR_KEY_COS = 4'b1101,
    EAR_KEY_DP_COS = 4'b1110,
    EAR_KEY_RSVD = 4'b1111
  } ear_key_e;

endpackage

// *** rtl/ear_egress_action_resolver.sv ***
// Egress action resolver: encapsulation, pop count, counter and mapping indices
//
// Contract
// - Encapsulation index 1..127 selects an entry; zero pushes no encapsulation.
// - Alternate encapsulation index, same encoding, replaces primary when protection enables it.
// - Pop override 0 uses header count, 1 pops nothing, 2..21 pops 2n bytes.
// - Pop override values 22..31 are reserved; no defined popping behaviour.
// - Override popping more than header count falls back to the header count.
// - Service counter base forms the egress service index.
// - Alternate service counter base replaces primary when protection enables it.
// - Statistics index is base plus 3-bit per-class offset chosen by class.
// - Mapping indices zero and one address resource A: field in bits 10:3 plus key offset.
// - Mapping indices two and three address resource B; index three uses key three.
// - Key 0 adds QoS class; key 1 adds drop precedence times 8 plus QoS.
// - Key 2 adds DSCP; key 3 adds 64 DP plus DSCP; key 4 adds 8 DP plus TOS.
// - Key 5 adds PCP; key 6 adds 8 DP plus PCP; key 7 adds 8 DEI plus PCP.
// - Key 8 adds traffic class; key 9 adds 8 DP plus traffic class.
// - Keys 10..12 use popped tag: PCP, 8 DP plus PCP, 8 DEI plus PCP.
// - Keys 13 and 14 use service class id, key 14 with drop precedence.
// - Four independent mapping keys, one per table, all sharing one encoding.
// - Protection 1 uses alternates when active, 2 when inactive, 0 never.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module ear_egress_action_resolver (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ear_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ear_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [ear_pkg::DATA_W-1:0] reg_rdata,
  input wire logic action_valid,
  input wire logic [ear_pkg::ENCAP_W-1:0] encap_table_index,
  input wire logic [ear_pkg::ENCAP_W-1:0] encap_table_index_alt,
  input wire logic [ear_pkg::POP_W-1:0] pop_word_override,
  input wire logic [ear_pkg::BASE_W-1:0] service_counter_base,
  input wire logic [ear_pkg::BASE_W-1:0] service_counter_base_alt,
  input wire logic [ear_pkg::OFFS_W-1:0] per_class_counter_offsets,
  input wire logic [ear_pkg::MIDX_W-1:0] mapping_index_zero,
  input wire logic [ear_pkg::MIDX_W-1:0] mapping_index_one,
  input wire logic [ear_pkg::MIDX_W-1:0] mapping_index_two,
  input wire logic [ear_pkg::MIDX_W-1:0] mapping_index_three,
  input wire logic [ear_pkg::KEY_W-1:0] mapping_key_zero,
  input wire logic [ear_pkg::KEY_W-1:0] mapping_key_one,
  input wire logic [ear_pkg::KEY_W-1:0] mapping_key_two,
  input wire logic [ear_pkg::KEY_W-1:0] mapping_key_three,
  input wire logic [1:0] protection_choice,
  input wire logic prot_active,
  input wire logic [ear_pkg::POP_W-1:0] header_pop_words,
  input wire logic [2:0] service_class_id,
  input wire logic [1:0] drop_precedence,
  input wire logic [2:0] qos_class,
  input wire logic [5:0] header_dscp,
  input wire logic [2:0] tos_precedence_bits,
  input wire logic [2:0] pcp,
  input wire logic dei,
  input wire logic [2:0] traffic_class,
  input wire logic [2:0] popped_pcp,
  input wire logic popped_dei,
  output logic result_valid,
  output logic encap_push,
  output logic [ear_pkg::ENCAP_W-1:0] encap_index_out,
  output logic [ear_pkg::POP_W-1:0] pop_words_out,
  output logic pop_reserved,
  output logic [ear_pkg::BASE_W-1:0] service_index,
  output logic [ear_pkg::BASE_W-1:0] stat_index,
  output logic [ear_pkg::MAP_W-1:0] map_a_first_index,
  output logic [ear_pkg::MAP_W-1:0] map_a_second_index,
  output logic [ear_pkg::MAP_W-1:0] map_b_first_index,
  output logic [ear_pkg::MAP_W-1:0] map_b_second_index,
  output logic [3:0] map_valid
);
  import ear_pkg::*;

  // ==========================================================
  // Offset builder shared by all four mapping keys
  function automatic logic [8:0] ear_key_offset(
    input logic [KEY_W-1:0] key,
    input logic [1:0] dp,
    input logic [2:0] qos,
    input logic [5:0] dscp,
    input logic [2:0] tos,
    input logic [2:0] pc,
    input logic de,
    input logic [2:0] tc,
    input logic [2:0] ppc,
    input logic pde,
    input logic [2:0] cos
  );
    logic [8:0] r;
    r = 9'h000;
    case (key)
      EAR_KEY_QOS: r = {1'b1, 5'h00, qos};
      EAR_KEY_DP_QOS: r = {1'b1, 3'h0, dp, qos};
      EAR_KEY_DSCP: r = {1'b1, 2'h0, dscp};
      EAR_KEY_DP_DSCP: r = {1'b1, dp, dscp};
      EAR_KEY_DP_TOS: r = {1'b1, 3'h0, dp, tos};
      EAR_KEY_PCP: r = {1'b1, 5'h00, pc};
      EAR_KEY_DP_PCP: r = {1'b1, 3'h0, dp, pc};
      EAR_KEY_DEI_PCP: r = {1'b1, 4'h0, de, pc};
      EAR_KEY_TC: r = {1'b1, 5'h00, tc};
      EAR_KEY_DP_TC: r = {1'b1, 3'h0, dp, tc};
      EAR_KEY_POP_PCP: r = {1'b1, 5'h00, ppc};
      EAR_KEY_DP_POP_PCP: r = {1'b1, 3'h0, dp, ppc};
      EAR_KEY_POP_DEI_PCP: r = {1'b1, 4'h0, pde, ppc};
      EAR_KEY_COS: r = {1'b1, 5'h00, cos};
      EAR_KEY_DP_COS: r = {1'b1, 3'h0, dp, cos};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Register state
  logic ctrl_enable;
  logic [CNT_W-1:0] frame_count;
  logic [CNT_W-1:0] rsvd_count;

  // Register decode
  wire logic sel_ctrl = (reg_addr == ADDR_CTRL);
  wire logic sel_status = (reg_addr == ADDR_STATUS);
  wire logic wr_ctrl = reg_we && sel_ctrl;
  wire logic wr_status = reg_we && sel_status;
  wire logic [DATA_W-1:0] ctrl_word = {{(DATA_W-1){1'b0}}, ctrl_enable};
  wire logic [DATA_W-1:0] status_word = {rsvd_count, frame_count};
  wire logic [DATA_W-1:0] next_rdata = sel_ctrl ? ctrl_word : (sel_status ? status_word : 32'h0000_0000);

  // ==========================================================
  // Action acceptance
  wire logic take = ce && action_valid && ctrl_enable && !rst;

  // Protection choice decode
  wire logic use_alt = (protection_choice == EAR_PROT_ACTIVE && prot_active) ||
                       (protection_choice == EAR_PROT_INACTIVE && !prot_active);

  // Encapsulation selection
  wire logic [ENCAP_W-1:0] next_encap = use_alt ? encap_table_index_alt : encap_table_index;
  wire logic next_push = (next_encap != 7'h00);

  // Service and statistics indices
  wire logic [BASE_W-1:0] next_service = use_alt ? service_counter_base_alt : service_counter_base;
  wire logic [2:0] class_offset = per_class_counter_offsets[3*service_class_id +: 3];
  wire logic [BASE_W-1:0] next_stat = next_service + {7'h00, class_offset};

  // ==========================================================
  // Pop word resolution
  wire logic pop_rsvd_in = (pop_word_override > POP_MAX);
  wire logic [POP_W-1:0] pop_eff = (pop_word_override == POP_NONE) ? 5'h00 : pop_word_override;
  wire logic pop_use_hdr = (pop_word_override == POP_USE_HEADER) || pop_rsvd_in ||
                           (pop_eff > header_pop_words);
  wire logic [POP_W-1:0] next_pop = pop_use_hdr ? header_pop_words : pop_eff;

  // ==========================================================
  // Mapping index formation, one lane per table
  wire logic [MIDX_W-1:0] midx [4];
  wire logic [KEY_W-1:0] mkey [4];
  wire logic [8:0] moff [4];
  wire logic [MAP_W-1:0] next_map [4];
  logic [MAP_W-1:0] map_q [4];
  assign midx[0] = mapping_index_zero;
  assign midx[1] = mapping_index_one;
  assign midx[2] = mapping_index_two;
  assign midx[3] = mapping_index_three;
  assign mkey[0] = mapping_key_zero;
  assign mkey[1] = mapping_key_one;
  assign mkey[2] = mapping_key_two;
  assign mkey[3] = mapping_key_three;

  // Each table keeps its own key and base
  generate
    for (genvar i = 0; i < 4; i++) begin : g_map
      assign moff[i] = ear_key_offset(mkey[i], drop_precedence, qos_class, header_dscp,
                                      tos_precedence_bits, pcp, dei, traffic_class,
                                      popped_pcp, popped_dei, service_class_id);
      assign next_map[i] = {midx[i], 3'h0} + {3'h0, moff[i][7:0]};
    end
  endgenerate

  // Hold all four lane results in one process, so the array has a single driver
  always_ff @(posedge clock) begin
    if (rst) begin
      map_q <= '{default: 11'h000};
    end else if (take) begin
      map_q <= next_map;
    end
  end

  wire logic [3:0] next_valid = {moff[3][8], moff[2][8], moff[1][8], moff[0][8]};
  wire logic key_rsvd_in = (next_valid != 4'hf);

  // Resource A lanes, then resource B lanes
  assign map_a_first_index = map_q[0];
  assign map_a_second_index = map_q[1];
  assign map_b_first_index = map_q[2];
  assign map_b_second_index = map_q[3];

  // ==========================================================
  // Result registers
  always_ff @(posedge clock) begin
    if (rst) begin
      result_valid <= 1'b0;
      encap_push <= 1'b0;
      encap_index_out <= 7'h00;
      pop_words_out <= 5'h00;
      pop_reserved <= 1'b0;
      service_index <= 10'h000;
      stat_index <= 10'h000;
      map_valid <= 4'h0;
    end else if (ce) begin
      result_valid <= take;
      if (take) begin
        encap_push <= next_push;
        encap_index_out <= next_encap;
        pop_words_out <= next_pop;
        pop_reserved <= pop_rsvd_in;
        service_index <= next_service;
        stat_index <= next_stat;
        map_valid <= next_valid;
      end
    end
  end

  // ==========================================================
  // Control register and status counters; a counted event in the cycle of a clear leaves the count at one
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_enable <= CTRL_RESET[CTRL_ENABLE_BIT];
      frame_count <= 16'h0000;
      rsvd_count <= 16'h0000;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_enable <= reg_wdata[CTRL_ENABLE_BIT];
      end
      if (take) begin
        frame_count <= wr_status ? 16'h0001 : frame_count + 16'h0001;
      end else if (wr_status) begin
        frame_count <= 16'h0000;
      end
      if (take && (pop_rsvd_in || key_rsvd_in)) begin
        rsvd_count <= wr_status ? 16'h0001 : rsvd_count + 16'h0001;
      end else if (wr_status) begin
        rsvd_count <= 16'h0000;
      end
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_re ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_take_alt_active;
    take && protection_choice == EAR_PROT_ACTIVE && prot_active;
  endsequence

  sequence s_take_alt_inactive;
    take && protection_choice == EAR_PROT_INACTIVE && !prot_active;
  endsequence

  sequence s_take_primary;
    take && protection_choice == EAR_PROT_NONE;
  endsequence

  a_encap_zero_push: assert property (
    s_take_primary and (encap_table_index == 7'h00) |=> !encap_push && encap_index_out == 7'h00)
    else $error("zero encapsulation index still pushes");

  a_encap_alt_sel: assert property (
    s_take_alt_active |=> encap_index_out == $past(encap_table_index_alt))
    else $error("alternate encapsulation index not selected");

  a_pop_header: assert property (
    take && pop_word_override == POP_USE_HEADER |=> pop_words_out == $past(header_pop_words))
    else $error("pop override zero did not use header count");

  a_pop_none: assert property (
    take && pop_word_override == POP_NONE |=> pop_words_out == 5'h00)
    else $error("pop override one did not pop zero");

  a_pop_clamp: assert property (
    take && pop_word_override > POP_NONE && pop_word_override <= POP_MAX &&
    pop_word_override > header_pop_words |=> pop_words_out == $past(header_pop_words))
    else $error("oversized pop override not replaced by header count");

  a_pop_reserved: assert property (
    take |=> pop_reserved == ($past(pop_word_override) > POP_MAX))
    else $error("reserved pop override flag wrong");

  a_service_primary: assert property (
    s_take_primary |=> service_index == $past(service_counter_base))
    else $error("primary service base not used");

  a_service_alt: assert property (
    s_take_alt_inactive |=> service_index == $past(service_counter_base_alt))
    else $error("alternate service base not used");

  a_stat_offset: assert property (
    take |=> stat_index == 10'(service_index + {7'h00, $past(class_offset)}))
    else $error("statistics index offset wrong");

  a_map_qos: assert property (
    take && mapping_key_zero == EAR_KEY_QOS |=>
    map_a_first_index == 11'({$past(mapping_index_zero), 3'h0} + {8'h00, $past(qos_class)}))
    else $error("QoS mapping index wrong");

  a_map_dp_dscp: assert property (
    take && mapping_key_three == EAR_KEY_DP_DSCP |=> map_valid[3] &&
    map_b_second_index == 11'({$past(mapping_index_three), 3'h0} +
    {3'h0, $past(drop_precedence), $past(header_dscp)}))
    else $error("DP and DSCP mapping index wrong");

  a_map_rsvd_key: assert property (
    take && mapping_key_one == EAR_KEY_RSVD |=> !map_valid[1])
    else $error("reserved mapping key gave a valid result");

  a_result_pulse: assert property (
    ce && !take |=> !result_valid)
    else $error("result valid without an accepted action");

  a_map_dei_pcp: assert property (
    take && mapping_key_zero == EAR_KEY_DEI_PCP |=>
    map_a_first_index == 11'({$past(mapping_index_zero), 3'h0} + {7'h00, $past(dei), $past(pcp)}))
    else $error("DEI and PCP mapping index wrong");

  a_map_dp_qos: assert property (
    take && mapping_key_one == EAR_KEY_DP_QOS |=>
    map_a_second_index == 11'({$past(mapping_index_one), 3'h0} +
    {6'h00, $past(drop_precedence), $past(qos_class)}))
    else $error("second resource A index wrong");

  a_map_pop_tag: assert property (
    take && mapping_key_two == EAR_KEY_POP_DEI_PCP |=>
    map_b_first_index == 11'({$past(mapping_index_two), 3'h0} + {7'h00, $past(popped_dei), $past(popped_pcp)}))
    else $error("popped tag mapping index wrong");

  a_map_dp_cos: assert property (
    take && mapping_key_three == EAR_KEY_DP_COS |=>
    map_b_second_index == 11'({$past(mapping_index_three), 3'h0} +
    {6'h00, $past(drop_precedence), $past(service_class_id)}))
    else $error("DP and class mapping index wrong");

  a_freeze_hold: assert property (
    !ce |=> $stable(result_valid) && $stable(stat_index) && $stable(map_valid))
    else $error("outputs moved while clock enable was low");

endmodule

// *** dv/ear_sink_model.sv ***
// Far-side model: service counters consuming resolved actions
`timescale 1ns/10ps
module ear_sink_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic result_valid,
  input wire logic encap_push,
  input wire logic [ear_pkg::BASE_W-1:0] stat_index,
  output logic [15:0] frames_seen,
  output logic [15:0] pushes_seen,
  output logic [ear_pkg::BASE_W-1:0] last_stat
);
  import ear_pkg::*;

  // ==========================================================
  // Counter set update, one per resolved action; never stalls the resolver
  always_ff @(posedge clock) begin
    if (rst) begin
      frames_seen <= 16'h0000;
      pushes_seen <= 16'h0000;
      last_stat <= 10'h000;
    end else if (result_valid) begin
      frames_seen <= frames_seen + 16'h0001;
      pushes_seen <= pushes_seen + 16'(encap_push);
      last_stat <= stat_index;
    end
  end
endmodule

// *** dv/ear_egress_action_resolver_tb.sv ***
// Self-checking bench for the egress action resolver
`timescale 1ns/10ps
module ear_egress_action_resolver_tb;
  import ear_pkg::*;

  // ==========================================================
  // Action and frame fields driven as one bundle
  typedef struct packed {
    logic [6:0] enc, enc_alt;
    logic [4:0] ov, hp;
    logic [9:0] base, base_alt;
    logic [23:0] offs;
    logic [3:0][7:0] idx;
    logic [3:0][3:0] key;
    logic [1:0] pc, dp;
    logic [2:0] cls, qos, tos, pcp, tc, ppcp;
    logic [5:0] dscp;
    logic pa, dei, pdei;
  } ear_tb_fld_s;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic action_valid = 1'b0;
  ear_tb_fld_s cur = '0;
  logic [31:0] reg_rdata;
  logic result_valid, encap_push, pop_reserved;
  logic [6:0] encap_index_out;
  logic [4:0] pop_words_out;
  logic [9:0] service_index, stat_index, last_stat;
  wire logic [3:0][10:0] map_out;
  logic [9:0] exp_stat = 10'h000;
  logic [3:0] map_valid;
  logic [15:0] frames_seen, pushes_seen;
  int err_total = 0;
  int compares = 0;
  int n_rsv = 0;
  int n_push = 0;

  always #5 clock = ~clock;

  ear_egress_action_resolver dut (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .action_valid(action_valid),
    .encap_table_index(cur.enc), .encap_table_index_alt(cur.enc_alt), .pop_word_override(cur.ov),
    .service_counter_base(cur.base), .service_counter_base_alt(cur.base_alt), .per_class_counter_offsets(cur.offs),
    .mapping_index_zero(cur.idx[0]), .mapping_index_one(cur.idx[1]), .mapping_index_two(cur.idx[2]),
    .mapping_index_three(cur.idx[3]), .mapping_key_zero(cur.key[0]), .mapping_key_one(cur.key[1]),
    .mapping_key_two(cur.key[2]), .mapping_key_three(cur.key[3]), .protection_choice(cur.pc),
    .prot_active(cur.pa), .header_pop_words(cur.hp), .service_class_id(cur.cls), .drop_precedence(cur.dp),
    .qos_class(cur.qos), .header_dscp(cur.dscp), .tos_precedence_bits(cur.tos), .pcp(cur.pcp), .dei(cur.dei),
    .traffic_class(cur.tc), .popped_pcp(cur.ppcp), .popped_dei(cur.pdei), .result_valid(result_valid),
    .encap_push(encap_push), .encap_index_out(encap_index_out), .pop_words_out(pop_words_out),
    .pop_reserved(pop_reserved), .service_index(service_index), .stat_index(stat_index),
    .map_a_first_index(map_out[0]), .map_a_second_index(map_out[1]), .map_b_first_index(map_out[2]),
    .map_b_second_index(map_out[3]), .map_valid(map_valid));

  ear_sink_model sink (.clock(clock), .rst(rst), .result_valid(result_valid), .encap_push(encap_push),
    .stat_index(stat_index), .frames_seen(frames_seen), .pushes_seen(pushes_seen), .last_stat(last_stat));

  // ==========================================================
  // Comparison, register access and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Field pattern for action j, varied so every key and mode is hit
  function automatic ear_tb_fld_s fld(input int j);
    ear_tb_fld_s f;
    f.enc = 7'(j);
    f.enc_alt = 7'(j * 5);
    f.ov = 5'(j);
    f.hp = 5'(6 + j % 12);
    f.base = 10'(j * 29 + 1000);
    f.base_alt = 10'(j * 61);
    f.offs = 24'(j * 24'h5a_3c71);
    for (int t = 0; t < 4; t++) begin
      f.idx[t] = 8'(255 - j * 7 + t * 64);
      f.key[t] = 4'(j + t * 5);
    end
    f.pc = 2'(j);
    f.pa = 1'(j >> 2);
    f.cls = 3'(j * 3);
    f.dp = 2'(j / 3);
    f.qos = 3'(j);
    f.dscp = 6'(j * 11);
    f.tos = 3'(j * 5);
    f.pcp = 3'(j + 1);
    f.dei = 1'(j >> 1);
    f.tc = 3'(j + 3);
    f.ppcp = 3'(j * 3 + 2);
    f.pdei = 1'(j >> 3);
    return f;
  endfunction

  // Expected mapping address: field in bits 10:3 plus key-selected offset, 11-bit wrap
  function automatic logic [10:0] map_exp(input ear_tb_fld_s f, input int t);
    logic [10:0] off;
    case (f.key[t])
      4'h0: off = 11'(f.qos);
      4'h1: off = 11'({f.dp, f.qos});
      4'h2: off = 11'(f.dscp);
      4'h3: off = 11'({f.dp, f.dscp});
      4'h4: off = 11'({f.dp, f.tos});
      4'h5: off = 11'(f.pcp);
      4'h6: off = 11'({f.dp, f.pcp});
      4'h7: off = 11'({f.dei, f.pcp});
      4'h8: off = 11'(f.tc);
      4'h9: off = 11'({f.dp, f.tc});
      4'ha: off = 11'(f.ppcp);
      4'hb: off = 11'({f.dp, f.ppcp});
      4'hc: off = 11'({f.pdei, f.ppcp});
      4'hd: off = 11'(f.cls);
      4'he: off = 11'({f.dp, f.cls});
      default: off = 11'h000;
    endcase
    return {f.idx[t], 3'h0} + off;
  endfunction

  // Checks the result of action j, one cycle after it was taken
  task automatic check(input int j);
    ear_tb_fld_s f;
    logic alt;
    logic [6:0] enc;
    logic [4:0] pexp;
    logic [9:0] base;
    logic rsv;
    f = fld(j);
    alt = (f.pc == 2'h1 && f.pa) || (f.pc == 2'h2 && !f.pa);
    enc = alt ? f.enc_alt : f.enc;
    base = alt ? f.base_alt : f.base;
    if (f.ov == POP_USE_HEADER || f.ov > POP_MAX) pexp = f.hp;
    else if (f.ov == POP_NONE) pexp = 5'h00;
    else pexp = (f.ov > f.hp) ? f.hp : f.ov;
    rsv = f.ov > POP_MAX;
    chk(32'(result_valid), 32'h0000_0001);
    chk(32'(encap_index_out), 32'(enc));
    chk(32'(encap_push), 32'(enc != 7'h00));
    chk(32'(pop_words_out), 32'(pexp));
    chk(32'(pop_reserved), 32'(rsv));
    chk(32'(service_index), 32'(base));
    exp_stat = 10'(base + 10'(f.offs[3 * f.cls +: 3]));
    chk(32'(stat_index), 32'(exp_stat));
    for (int t = 0; t < 4; t++) begin
      chk(32'(map_out[t]), 32'(map_exp(f, t)));
      chk(32'(map_valid[t]), 32'(f.key[t] != 4'hf));
      rsv = rsv || (f.key[t] == 4'hf);
    end
    n_rsv += int'(rsv);
    n_push += int'(enc != 7'h00);
  endtask

  // ==========================================================
  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    err_total++;
    summarize();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(32'({result_valid, map_valid, stat_index}), 32'h0000_0000);
    reg_read(ADDR_CTRL, CTRL_RESET);
    reg_read(ADDR_STATUS, 32'h0000_0000);
    reg_read(4'h8, 32'h0000_0000);
    $display("reset test done");
    // Back-to-back actions, each result checked as the next is offered
    for (int i = 0; i <= 32; i++) begin
      @(posedge clock);
      if (i < 32) cur <= fld(i);
      action_valid <= (i < 32);
      #1;
      if (i > 0) check(i - 1);
    end
    @(posedge clock);
    #1;
    chk(32'(result_valid), 32'h0000_0000);
    chk(32'(frames_seen), 32'd32);
    chk(32'(pushes_seen), 32'(n_push));
    chk(32'(last_stat), 32'(exp_stat));
    reg_read(ADDR_STATUS, {16'(n_rsv), 16'h0020});
    $display("sweep test done");
    reg_write(ADDR_STATUS, 32'h0000_0000);
    reg_read(ADDR_STATUS, 32'h0000_0000);
    reg_write(4'hc, 32'h0000_0000);
    reg_read(ADDR_CTRL, CTRL_RESET);
    // Disabled resolver ignores an offered action; frozen clock enable ignores a control write
    reg_write(ADDR_CTRL, 32'h0000_0000);
    @(posedge clock);
    cur <= fld(3);
    action_valid <= 1'b1;
    @(posedge clock);
    ce <= 1'b0;
    reg_write(ADDR_CTRL, CTRL_RESET);
    @(posedge clock);
    ce <= 1'b1;
    action_valid <= 1'b0;
    #1;
    chk(32'(result_valid), 32'h0000_0000);
    reg_read(ADDR_STATUS, 32'h0000_0000);
    chk(32'(frames_seen), 32'd32);
    reg_read(ADDR_CTRL, 32'h0000_0000);
    $display("refusal test done");
    // Mid-run reset restores defaults, then a frozen clock enable holds back an action
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(32'({encap_index_out, stat_index}), 32'h0000_0000);
    chk(32'(frames_seen), 32'h0000_0000);
    reg_read(ADDR_CTRL, CTRL_RESET);
    @(posedge clock);
    ce <= 1'b0;
    action_valid <= 1'b1;
    @(posedge clock);
    ce <= 1'b1;
    action_valid <= 1'b0;
    #1;
    chk(32'(result_valid), 32'h0000_0000);
    reg_read(ADDR_STATUS, 32'h0000_0000);
    $display("reset and freeze test done");
    summarize();
  end
endmodule
